// ==== src/dmr_regs.sv ====
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defines.svh"
module dmr_regs
  import dmr_pkg::*;
#(
  parameter int unsigned ADDR_W       = 16,
  parameter logic [63:0] RANGE_SIZE   = `DMR_RANGE_SIZE,
  parameter logic [63:0] BACKED_BYTES = `DMR_RANGE_SIZE,
  parameter logic [2:0]  MEDIA_TYPE   = `DMR_MEDIA_VOLATILE,
  parameter logic [2:0]  MEM_CLASS    = `DMR_CLASS_MEM,
  parameter logic [2:0]  INTERLEAVE   = `DMR_ILV_NONE,
  parameter bit          HW_INIT_A    = 1'b1,
  parameter int unsigned READY_CYC    = `DMR_READY_CYC,
  parameter int unsigned INFO_CYC     = `DMR_INFO_CYC,
  parameter int unsigned WIN_LOG2     = `DMR_WIN_LOG2
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  // Device memory side
  input  wire logic              init_done_i,
  input  wire logic              lookup_valid_i,
  input  wire logic [63:0]       lookup_addr_i,
  output logic                   claim_o,
  output logic                   local_sel_o,
  output logic                   fill_ones_o,
  // Placement of windows and port blocks, range ready and decode enable
  output logic [63:0]            dwin_base_o,
  output logic [63:0]            uwin_base_o,
  output logic                   win_valid_o,
  output logic [63:0]            blk_base_o,
  output logic                   range_ready_o,
  output logic                   mem_enable_o
);
  localparam logic [ADDR_W-1:0] BLK_REG  = ADDR_W'(`DMR_BLK_REGION);
  localparam dmr_addr_t         WIN_MASK = ~((64'h1 << WIN_LOG2) - 64'h1);

  // Parameter checks
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie in 14..32");
  end
  if (RANGE_SIZE[27:0] != 28'h0) begin : g_bad_size
    $error("RANGE_SIZE must be a multiple of 256 MB");
  end
  if (BACKED_BYTES > RANGE_SIZE) begin : g_bad_backed
    $error("BACKED_BYTES exceeds RANGE_SIZE");
  end
  if (MEDIA_TYPE != `DMR_MEDIA_VOLATILE && MEDIA_TYPE != `DMR_MEDIA_NONVOL &&
      MEDIA_TYPE != `DMR_MEDIA_NOTMEM) begin : g_bad_media
    $error("MEDIA_TYPE is a reserved code");
  end
  if (MEM_CLASS != `DMR_CLASS_MEM && MEM_CLASS != `DMR_CLASS_STORAGE) begin : g_bad_class
    $error("MEM_CLASS is a reserved code");
  end
  if (INTERLEAVE != `DMR_ILV_NONE && INTERLEAVE != `DMR_ILV_256B &&
      INTERLEAVE != `DMR_ILV_4K) begin : g_bad_ilv
    $error("INTERLEAVE is a reserved code");
  end
  if (WIN_LOG2 < 4 || WIN_LOG2 > 40) begin : g_bad_win
    $error("WIN_LOG2 must lie in 4..40");
  end
  if (READY_CYC < 2 || INFO_CYC < 1 || INFO_CYC >= READY_CYC) begin : g_bad_cyc
    $error("Need 1 <= INFO_CYC < READY_CYC and READY_CYC >= 2");
  end

  // Stored state
  logic         ack_q;
  logic         err_q;
  logic [31:0]  dat_q;
  logic         lock_q;
  logic         mem_enable_q;
  logic [31:0]  base_hi_q;
  logic [3:0]   base_lo_q;
  logic [63:13] blk_base_q;
  logic [63:0]  dbar_q;
  logic [63:0]  ubar_q;

  // Bus decode
  logic         req;
  logic         wr;
  logic         low_sel;
  logic         blk_sel;
  logic         blk_up;
  logic [11:0]  off;
  logic [31:0]  rd_data;
  logic         rd_hit;
  logic [31:0]  size_lo_word;

  // Merged write words
  logic [31:0]  m_base_hi;
  logic [31:0]  m_base_lo;
  logic [31:0]  m_blk_lo;
  logic [31:0]  m_blk_hi;
  logic [31:0]  m_bar_lo;
  logic [31:0]  m_bar_hi;
  logic [63:0]  bar_sel;
  logic         wr_bar_lo;
  logic         wr_bar_hi;

  dmr_cfg_if cfg ();

  // New request: only while no answer is standing
  assign req     = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign wr      = req & wb_we_i;
  assign off     = wb_adr_i[11:0];
  assign low_sel = (wb_adr_i[ADDR_W-1:12] == '0);
  assign blk_sel = (wb_adr_i[ADDR_W-1:13] == BLK_REG[ADDR_W-1:13]);
  assign blk_up  = wb_adr_i[12];

  // Size low status word, reserved bits zero
  assign size_lo_word = {RANGE_SIZE[31:28],
                         17'h0,
                         INTERLEAVE,
                         MEM_CLASS,
                         MEDIA_TYPE,
                         cfg.range_ready,
                         cfg.info_valid};

  // Read multiplexer
  always_comb begin
    rd_data = 32'h0;
    rd_hit  = 1'b0;
    bar_sel = blk_up ? ubar_q : dbar_q;
    if (low_sel) begin
      rd_hit = 1'b1;
      case (off)
        `DMR_OFF_SIZE_HI: rd_data = RANGE_SIZE[63:32];
        `DMR_OFF_SIZE_LO: rd_data = size_lo_word;
        `DMR_OFF_BASE_HI: rd_data = base_hi_q;
        `DMR_OFF_BASE_LO: rd_data = {base_lo_q, 28'h0};
        `DMR_OFF_CTRL:    rd_data = {31'h0, mem_enable_q};
        `DMR_OFF_LOCK:    rd_data = {31'h0, lock_q};
        `DMR_OFF_STATUS:  rd_data = {31'h0, cfg.conflict};
        `DMR_OFF_BLK_LO:  rd_data = {blk_base_q[31:13], 13'h0};
        `DMR_OFF_BLK_HI:  rd_data = blk_base_q[63:32];
        default:          rd_hit  = 1'b0;
      endcase
    end else if (blk_sel) begin
      // Whole 4K of each block answers; unlisted words read zero
      rd_hit = 1'b1;
      case (off)
        `DMR_BLK_OFF_CAPHDR:  rd_data = `DMR_CAPHDR_VAL;
        `DMR_BLK_OFF_HDRTYPE: rd_data = blk_up ? {8'h0, `DMR_HDRTYPE_UP, 16'h0} :
                                                  {8'h0, `DMR_HDRTYPE_DOWN, 16'h0};
        `DMR_BLK_OFF_BAR_LO:  rd_data = bar_sel[31:0];
        `DMR_BLK_OFF_BAR_HI:  rd_data = bar_sel[63:32];
        default:              rd_data = 32'h0;
      endcase
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & rd_hit;
      err_q <= req & ~rd_hit;
      if (req && !wb_we_i) begin
        dat_q <= rd_hit ? rd_data : 32'h0;
      end
    end
  end

  // Write-once lock, cleared only by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (wr && low_sel && off == `DMR_OFF_LOCK && wb_sel_i[0] && wb_dat_i[`DMR_LOCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  // Decode enable in the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_enable_q <= 1'b0;
    end else if (wr && low_sel && off == `DMR_OFF_CTRL && !lock_q && wb_sel_i[0]) begin
      mem_enable_q <= wb_dat_i[`DMR_CTRL_ENABLE_BIT];
    end
  end

  // Range base registers
  assign m_base_hi = dmr_merge(base_hi_q, wb_dat_i, wb_sel_i);
  assign m_base_lo = dmr_merge({base_lo_q, 28'h0}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_hi_q <= `DMR_RST_BASE_HI;
      base_lo_q <= `DMR_RST_BASE_LO;
    end else if (wr && low_sel && !lock_q) begin
      if (off == `DMR_OFF_BASE_HI) begin
        base_hi_q <= m_base_hi;
      end
      if (off == `DMR_OFF_BASE_LO) begin
        base_lo_q <= m_base_lo[31:28];
      end
    end
  end

  // Relocation of the 8K port block pair
  assign m_blk_lo = dmr_merge({blk_base_q[31:13], 13'h0}, wb_dat_i, wb_sel_i);
  assign m_blk_hi = dmr_merge(blk_base_q[63:32], wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_base_q <= `DMR_RST_BLK_BASE;
    end else if (wr && low_sel) begin
      if (off == `DMR_OFF_BLK_LO) begin
        blk_base_q[31:13] <= m_blk_lo[31:13];
      end
      if (off == `DMR_OFF_BLK_HI) begin
        blk_base_q[63:32] <= m_blk_hi;
      end
    end
  end

  // Component window base registers in each port block
  assign wr_bar_lo = wr && blk_sel && off == `DMR_BLK_OFF_BAR_LO;
  assign wr_bar_hi = wr && blk_sel && off == `DMR_BLK_OFF_BAR_HI;
  assign m_bar_lo  = dmr_merge(bar_sel[31:0], wb_dat_i, wb_sel_i);
  assign m_bar_hi  = dmr_merge(bar_sel[63:32], wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbar_q <= `DMR_RST_BAR;
      ubar_q <= `DMR_RST_BAR;
    end else if (wr_bar_lo || wr_bar_hi) begin
      // Bits below the window size stay zero
      if (blk_up) begin
        ubar_q <= (wr_bar_hi ? {m_bar_hi, ubar_q[31:0]} : {ubar_q[63:32], m_bar_lo}) & WIN_MASK;
      end else begin
        dbar_q <= (wr_bar_hi ? {m_bar_hi, dbar_q[31:0]} : {dbar_q[63:32], m_bar_lo}) & WIN_MASK;
      end
    end
  end

  // Configuration carried to the helpers
  assign cfg.base       = {base_hi_q, base_lo_q};
  assign cfg.size       = RANGE_SIZE[63:28];
  assign cfg.mem_enable = mem_enable_q;
  assign cfg.blk_base   = blk_base_q;
  assign cfg.dbar       = dbar_q;
  assign cfg.ubar       = ubar_q;

  dmr_ready_timer #(
    .READY_CYC (READY_CYC),
    .INFO_CYC  (INFO_CYC),
    .HW_INIT_A (HW_INIT_A)
  ) u_timer (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .init_done_i (init_done_i),
    .cfg         (cfg.timer)
  );

  dmr_range_decode #(
    .WIN_LOG2     (WIN_LOG2),
    .BACKED_BYTES (BACKED_BYTES)
  ) u_decode (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .lookup_valid_i (lookup_valid_i),
    .lookup_addr_i  (lookup_addr_i),
    .cfg            (cfg.decode),
    .claim_o        (claim_o),
    .local_sel_o    (local_sel_o),
    .fill_ones_o    (fill_ones_o)
  );

  // Outputs
  assign wb_ack_o      = ack_q;
  assign wb_err_o      = err_q;
  assign wb_dat_o      = dat_q;
  assign dwin_base_o   = dbar_q;
  assign uwin_base_o   = ubar_q;
  assign win_valid_o   = ~cfg.conflict;
  assign blk_base_o    = {blk_base_q, 13'h0};
  assign range_ready_o = cfg.range_ready;
  assign mem_enable_o  = mem_enable_q;
endmodule // dmr_regs
`default_nettype wire

// ==== src/dmr_defines.svh ====
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH

// Register offsets in the low 4K of the bus space
`define DMR_OFF_SIZE_HI      12'h028
`define DMR_OFF_SIZE_LO      12'h02C
`define DMR_OFF_BASE_HI      12'h030
`define DMR_OFF_BASE_LO      12'h034
`define DMR_OFF_CTRL         12'h038
`define DMR_OFF_LOCK         12'h03C
`define DMR_OFF_STATUS       12'h040
`define DMR_OFF_BLK_LO       12'h044
`define DMR_OFF_BLK_HI       12'h048

// Port register blocks: 8K on the bus, downstream first
`define DMR_BLK_REGION       16'h2000
`define DMR_BLK_LOG2         12
`define DMR_BLK_PAIR_LOG2    13
`define DMR_BLK_OFF_CAPHDR   12'h000
`define DMR_BLK_OFF_HDRTYPE  12'h00C
`define DMR_BLK_OFF_BAR_LO   12'h010
`define DMR_BLK_OFF_BAR_HI   12'h014
`define DMR_CAPHDR_VAL       32'h1000_0000
`define DMR_HDRTYPE_DOWN     8'h01
`define DMR_HDRTYPE_UP       8'h00
`define DMR_HDRTYPE_LSB      16

// Field positions
`define DMR_INFO_VALID_BIT   0
`define DMR_READY_BIT        1
`define DMR_SIZE_LSB         28
`define DMR_CTRL_ENABLE_BIT  0
`define DMR_LOCK_BIT         0
`define DMR_CONFLICT_BIT     0

// Field encodings
`define DMR_MEDIA_VOLATILE   3'h0
`define DMR_MEDIA_NONVOL     3'h1
`define DMR_MEDIA_NOTMEM     3'h7
`define DMR_CLASS_MEM        3'h0
`define DMR_CLASS_STORAGE    3'h1
`define DMR_ILV_NONE         3'h0
`define DMR_ILV_256B         3'h1
`define DMR_ILV_4K           3'h2

// Reset values
`define DMR_RST_BASE_HI      32'h0000_0000
`define DMR_RST_BASE_LO      4'h0
`define DMR_RST_BAR          64'h0000_0000_0000_0000
`define DMR_RST_BLK_BASE     51'h0_0000_0000_7F00
`define DMR_RANGE_SIZE       64'h0000_0000_1000_0000
`define DMR_WIN_LOG2         16

// Timing
`define DMR_CLK_HZ           200000000
`define DMR_READY_LIMIT_S    1
`define DMR_READY_CYC        (`DMR_READY_LIMIT_S * `DMR_CLK_HZ)
`define DMR_INFO_CYC         16

`endif

// ==== src/dmr_pkg.sv ====
package dmr_pkg;

  // Ready timer states
  typedef enum logic [1:0] {
    DMR_TMR_COUNT = 2'b01,
    DMR_TMR_DONE  = 2'b10
  } dmr_tmr_state_t;

  typedef logic [63:0] dmr_addr_t;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] dmr_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Two half-open address windows share at least one byte
  function automatic logic dmr_overlap(input dmr_addr_t a,
                                       input dmr_addr_t a_len,
                                       input dmr_addr_t b,
                                       input dmr_addr_t b_len);
    logic [64:0] a_end;
    logic [64:0] b_end;
    a_end = {1'b0, a} + {1'b0, a_len};
    b_end = {1'b0, b} + {1'b0, b_len};
    return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
  endfunction

endpackage

// ==== src/dmr_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dmr_cfg_if;
  logic [63:28] base;
  logic [63:28] size;
  logic         mem_enable;
  logic         range_ready;
  logic         info_valid;
  logic [63:13] blk_base;
  logic [63:0]  dbar;
  logic [63:0]  ubar;
  logic         conflict;

  modport regs   (output base, size, mem_enable, blk_base, dbar, ubar,
                  input  range_ready, info_valid, conflict);
  modport timer  (output range_ready, info_valid);
  modport decode (input  base, size, mem_enable, range_ready, blk_base, dbar, ubar,
                  output conflict);
endinterface
`default_nettype wire

// ==== src/dmr_ready_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defines.svh"
module dmr_ready_timer
  import dmr_pkg::*;
#(
  parameter int unsigned READY_CYC = `DMR_READY_CYC,
  parameter int unsigned INFO_CYC  = `DMR_INFO_CYC,
  parameter bit          HW_INIT_A = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic init_done_i,
  dmr_cfg_if.timer  cfg
);
  dmr_tmr_state_t state_q;
  logic [31:0]    cnt_q;
  logic           info_q;
  logic           ready_q;

  // Count from reset release up to the ready limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DMR_TMR_COUNT;
      cnt_q   <= 32'h0;
    end else begin
      unique case (state_q)
        DMR_TMR_COUNT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(READY_CYC - 2)) begin
            state_q <= DMR_TMR_DONE;
          end
        end
        DMR_TMR_DONE: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // Size info valid after a short settle time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      info_q <= 1'b0;
    end else if (cnt_q == 32'(INFO_CYC - 1) || state_q == DMR_TMR_DONE) begin
      info_q <= 1'b1;
    end
  end

  // Ready on init done, or forced at the limit in hw init mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else if (init_done_i || (HW_INIT_A && state_q == DMR_TMR_DONE)) begin
      ready_q <= 1'b1;
    end
  end

  assign cfg.info_valid  = info_q;
  assign cfg.range_ready = ready_q;
endmodule // dmr_ready_timer
`default_nettype wire

// ==== src/dmr_range_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defines.svh"
module dmr_range_decode
  import dmr_pkg::*;
#(
  parameter int unsigned WIN_LOG2     = `DMR_WIN_LOG2,
  parameter logic [63:0] BACKED_BYTES = `DMR_RANGE_SIZE
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        lookup_valid_i,
  input  wire logic [63:0] lookup_addr_i,
  dmr_cfg_if.decode        cfg,
  output logic             claim_o,
  output logic             local_sel_o,
  output logic             fill_ones_o
);
  localparam dmr_addr_t WIN_LEN  = 64'h1 << WIN_LOG2;
  localparam dmr_addr_t PAIR_LEN = 64'h1 << `DMR_BLK_PAIR_LOG2;

  logic [36:0] limit;
  logic        in_range;
  logic        claim_d;
  logic [63:0] rel;
  logic        backed;
  logic        conflict_d;
  logic        conflict_q;

  // Range test in 256 MB units
  assign limit    = {1'b0, cfg.base} + {1'b0, cfg.size};
  assign in_range = ({1'b0, lookup_addr_i[63:28]} >= {1'b0, cfg.base}) &&
                    ({1'b0, lookup_addr_i[63:28]} < limit);
  assign claim_d  = lookup_valid_i & in_range & cfg.range_ready & cfg.mem_enable;
  assign rel      = lookup_addr_i - {cfg.base, 28'h0};
  assign backed   = rel < BACKED_BYTES;

  // Registered lookup answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      claim_o     <= 1'b0;
      local_sel_o <= 1'b0;
      fill_ones_o <= 1'b0;
    end else begin
      claim_o     <= claim_d;
      local_sel_o <= claim_d & backed;
      fill_ones_o <= claim_d & ~backed;
    end
  end

  // Port block pair against both component windows
  assign conflict_d = dmr_overlap({cfg.blk_base, 13'h0}, PAIR_LEN, cfg.dbar, WIN_LEN) |
                      dmr_overlap({cfg.blk_base, 13'h0}, PAIR_LEN, cfg.ubar, WIN_LEN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conflict_q <= 1'b0;
    end else begin
      conflict_q <= conflict_d;
    end
  end

  assign cfg.conflict = conflict_q;
endmodule // dmr_range_decode
`default_nettype wire

// ==== tb/dmr_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmr_regs_properties #(
  parameter int unsigned ADDR_W    = 16,
  parameter int unsigned READY_CYC = 64
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [31:0]       wb_dat_o,
  input  wire logic              wb_ack_o,
  input  wire logic              wb_err_o,
  input  wire logic              init_done_i,
  input  wire logic              lookup_valid_i,
  input  wire logic              claim_o,
  input  wire logic              local_sel_o,
  input  wire logic              fill_ones_o,
  input  wire logic [63:0]       blk_base_o,
  input  wire logic              range_ready_o,
  input  wire logic              mem_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] cnt_q;
  logic        lock_q;
  // Cycles since reset release, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end
  // Lock bit as taken from the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) lock_q <= 1'b0;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && wb_sel_i[0] && wb_dat_i[0]
             && wb_adr_i == ADDR_W'(16'h003C)) lock_q <= 1'b1;
  end
  answer_single_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("answer longer than one cycle");
  answer_cause_a: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  answer_excl_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
  err_read_zero_a: assert property ((wb_err_o && !$past(wb_we_i)) |-> wb_dat_o == 32'h0000_0000)
    else $error("refused read data not zero");
  claim_cause_a: assert property (claim_o |-> $past(lookup_valid_i && range_ready_o && mem_enable_o))
    else $error("claim without ready and enable");
  fill_kind_a: assert property (fill_ones_o |-> claim_o && !local_sel_o)
    else $error("fill without claim");
  ready_early_a: assert property ($rose(range_ready_o) |-> $past(init_done_i) || cnt_q >= READY_CYC)
    else $error("ready too early");
  ready_late_a: assert property (cnt_q > READY_CYC |-> range_ready_o)
    else $error("ready too late");
  lock_hold_a: assert property (lock_q |=> $stable(mem_enable_o))
    else $error("enable changed under lock");
  blk_align_a: assert property (blk_base_o[12:0] == 13'h0000)
    else $error("port block pair not 8K aligned");
endmodule // dmr_regs_properties

bind dmr_regs dmr_regs_properties #(.ADDR_W(ADDR_W), .READY_CYC(READY_CYC)) dmr_regs_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .init_done_i(init_done_i), .lookup_valid_i(lookup_valid_i),
  .claim_o(claim_o),
  .local_sel_o(local_sel_o), .fill_ones_o(fill_ones_o), .blk_base_o(blk_base_o),
  .range_ready_o(range_ready_o), .mem_enable_o(mem_enable_o));
`default_nettype wire

// ==== tb/dmr_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmr_mem_model #(
  parameter int unsigned INIT_CYC = 40
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      init_done_o
);
  int unsigned cnt_q;
  // Memory finishes its own initialisation some cycles after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= 0;
    else if (cnt_q < INIT_CYC) cnt_q <= cnt_q + 1;
  end
  assign init_done_o = (cnt_q >= INIT_CYC);
endmodule // dmr_mem_model
`default_nettype wire

// ==== tb/dmr_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dmr_regs_tb;
  typedef struct {logic we; logic [15:0] adr; logic [31:0] dat; logic [31:0] exp; logic err;} dmr_row_t;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, init_done_i, lookup_valid_i;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [63:0] lookup_addr_i, blk_base_o, dwin_base_o, uwin_base_o;
  logic        wb_ack_o, wb_err_o, claim_o, local_sel_o, fill_ones_o, range_ready_o, mem_enable_o, er;
  logic        win_valid_o;
  int          miscompares, total_checks;
  // Register rows: size fields, base, reserved bits, unmapped, port blocks
  dmr_row_t rows [0:13] = '{
    '{1'b0, 16'h002C, 32'h0, 32'h1000_0227, 1'b0}, '{1'b0, 16'h0028, 32'h0, 32'h0, 1'b0},
    '{1'b1, 16'h0030, 32'h0000_0001, 32'h0000_0001, 1'b0}, '{1'b1, 16'h0034, 32'hFFFF_FFFF, 32'hF000_0000, 1'b0},
    '{1'b1, 16'h002C, 32'h0, 32'h1000_0227, 1'b0}, '{1'b0, 16'h0100, 32'h0, 32'h0, 1'b1},
    '{1'b0, 16'h2000, 32'h0, 32'h1000_0000, 1'b0}, '{1'b0, 16'h200C, 32'h0, 32'h0001_0000, 1'b0},
    '{1'b0, 16'h300C, 32'h0, 32'h0, 1'b0}, '{1'b1, 16'h2014, 32'hA5A5_0001, 32'hA5A5_0001, 1'b0},
    '{1'b1, 16'h3010, 32'h1234_5678, 32'h1234_0000, 1'b0}, '{1'b0, 16'h4000, 32'h0, 32'h0, 1'b1},
    '{1'b1, 16'h3010, 32'h0FE0_0000, 32'h0FE0_0000, 1'b0}, '{1'b0, 16'h0040, 32'h0, 32'h0000_0001, 1'b0}};

  dmr_regs #(.READY_CYC(64), .MEDIA_TYPE(3'h1), .MEM_CLASS(3'h1), .INTERLEAVE(3'h2),
    .BACKED_BYTES(64'h0000_0000_0800_0000)) dmr_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .init_done_i(init_done_i), .lookup_valid_i(lookup_valid_i),
    .lookup_addr_i(lookup_addr_i), .claim_o(claim_o), .local_sel_o(local_sel_o), .fill_ones_o(fill_ones_o),
    .dwin_base_o(dwin_base_o), .uwin_base_o(uwin_base_o), .win_valid_o(win_valid_o), .blk_base_o(blk_base_o),
    .range_ready_o(range_ready_o), .mem_enable_o(mem_enable_o));
  dmr_mem_model dmr_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .init_done_o(init_done_i));

  // Clock at 200 MHz
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic Wishbone cycle held until ack or err is seen
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat,
                    output logic [31:0] rdat, output logic rerr);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 50);
    if (n >= 50) miscompares++;
    rdat = wb_dat_o;
    rerr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // One host lookup, answer seen one cycle later
  task automatic look(input logic [63:0] a, input logic c, input logic l, input logic f);
    @(posedge clk_i);
    lookup_valid_i <= 1'b1;
    lookup_addr_i  <= a;
    @(posedge clk_i);
    lookup_valid_i <= 1'b0;
    @(posedge clk_i);
    chk({61'h0, claim_o, local_sel_o, fill_ones_o}, {61'h0, c, l, f});
  endtask

  // Hang guard
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 16'h0000;
    wb_sel_i = 4'hF; wb_dat_i = 32'h0; lookup_valid_i = 1'b0; lookup_addr_i = 64'h0;
    miscompares = 0; total_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 16'h002C, 32'h0, rd, er);
    chk(rd[1:0], 2'h0);
    repeat (70) @(posedge clk_i);
    chk(range_ready_o, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].dat, rd, er);
      wb(1'b0, rows[i].adr, 32'h0, rd, er);
      chk({er, rd}, {rows[i].err, rows[i].exp});
    end
    // Upstream window now overlaps the port block pair
    chk(win_valid_o, 1'b0);
    chk(dwin_base_o, 64'hA5A5_0001_0000_0000);
    chk(uwin_base_o, 64'h0000_0000_0FE0_0000);
    chk(blk_base_o, 64'h0000_0000_0FE0_0000);
    // Relocate the pair with one byte lane, clearing the overlap
    wb_sel_i <= 4'h2;
    wb(1'b1, 16'h0048, 32'hFFFF_FFFF, rd, er);
    wb_sel_i <= 4'hF;
    wb(1'b0, 16'h0048, 32'h0, rd, er);
    chk(rd, 32'h0000_FF00);
    chk(blk_base_o, 64'h0000_FF00_0FE0_0000);
    chk(win_valid_o, 1'b1);
    // Base is 0x1_F000_0000, 256 MB claimed, 128 MB backed
    look(64'h0000_0001_F000_0010, 1'b0, 1'b0, 1'b0);
    wb(1'b1, 16'h0038, 32'h0000_0001, rd, er);
    look(64'h0000_0001_F000_0010, 1'b1, 1'b1, 1'b0);
    look(64'h0000_0001_F800_0000, 1'b1, 1'b0, 1'b1);
    look(64'h0000_0002_0000_0000, 1'b0, 1'b0, 1'b0);
    look(64'h0000_0001_EFFF_FFFF, 1'b0, 1'b0, 1'b0);
    // Lock, then attempt to change enable and base
    wb(1'b1, 16'h003C, 32'h0000_0001, rd, er);
    wb(1'b1, 16'h0038, 32'h0000_0000, rd, er);
    chk(mem_enable_o, 1'b1);
    wb(1'b1, 16'h0030, 32'h0000_0005, rd, er);
    wb(1'b0, 16'h0030, 32'h0, rd, er);
    chk(rd, 32'h0000_0001);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 16'h0030, 32'h0, rd, er);
    chk({range_ready_o, mem_enable_o, rd}, 34'h0);
    chk(blk_base_o, 64'h0000_0000_0FE0_0000);
    end_sim();
  end
endmodule // dmr_regs_tb
`default_nettype wire
